/* File: inc/vafe_pkg.sv */
// package: register map, field layout and control carriers of the video front end
package vafe_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_INPUT_CFG = 8'h05;
    localparam logic [7:0] IDX_RED_GAIN = 8'h06;
    localparam logic [7:0] IDX_GREEN_GAIN = 8'h07;
    localparam logic [7:0] IDX_BLUE_GAIN = 8'h08;
    localparam logic [7:0] IDX_RED_OFFSET = 8'h09;
    localparam logic [7:0] IDX_GREEN_OFFSET = 8'h0A;
    localparam logic [7:0] IDX_BLUE_OFFSET = 8'h0B;
    localparam logic [7:0] IDX_OFFSET_DAC_CFG = 8'h0C;
    localparam logic [7:0] IDX_STATUS = 8'h0D;
    localparam int ADDR_SHIFT = 2;
    localparam int ADDR_W = 8;

    // reset values
    localparam logic [7:0] RST_INPUT_CFG = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h55;
    localparam logic [7:0] RST_OFFSET = 8'h80;
    localparam logic [7:0] RST_OFFSET_DAC_CFG = 8'h00;

    // input configuration fields
    localparam int BIT_CHAN_SEL = 0;
    localparam int BIT_COUPLING = 1;
    localparam int BIT_COLOUR = 2;
    localparam int BIT_SYNC_TYPE = 3;
    localparam int BIT_COMPOSITE_SYNC_SRC = 4;
    localparam int BIT_COAST_CLAMP = 5;
    localparam logic [7:0] MASK_INPUT_CFG = 8'h3F;
    // offset dac configuration fields
    localparam int BIT_DAC_RANGE = 0;
    localparam int LSB_FIELD_BASE = 2;
    localparam logic [7:0] MASK_OFFSET_DAC_CFG = 8'hFD;

    // clamp dac level codes and black-level targets
    localparam logic [1:0] CLAMP_300MV = 2'h1;
    localparam logic [1:0] CLAMP_600MV = 2'h2;
    localparam logic [7:0] TARGET_ZERO = 8'h00;
    localparam logic [7:0] TARGET_MID = 8'h80;
    // channel order is red, green, blue
    localparam int GREEN_CH = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] clamp_level; // 300 or 600 mV code
        logic half_shift;
        logic [7:0] black_target;
        logic [7:0] gain;
        logic [9:0] dac_code;    // manual analog offset, latched on clamp
        logic [7:0] dig_offset;  // excess-128 digital offset
        logic pos_to_clamp;
        logic neg_to_clamp;
        logic neg_to_pad;
    } vafe_chan_t;

    typedef struct packed {
        logic input_select;      // 0 first_video_input, 1 second
        logic clamp_on;          // analog clamp signal
        logic restore_run;       // dc restore clamp active now
        logic loop_run;          // auto_black_level_loop running now
        logic loop_start;        // one-cycle start pulse for the loop
        logic dac_range;
        logic composite_mode;
        logic sync_out;
    } vafe_ctrl_t;
endpackage : vafe_pkg

/* File: verilog/vafe_regs.sv */
// file: register bank and analog control decode of the video front end
`timescale 1ns/10ps
module vafe_regs #(
    parameter int NUM_CHAN = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // axi4-lite write address and data
    input wire logic [vafe_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [vafe_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timing and sync pins from the analog side
    input wire logic clamp_pulse_pin,
    input wire logic coast_pin,
    input wire logic enable_loop_pin,
    input wire logic hsync_pin,
    input wire logic green_sync_input_pin,
    // analog controls
    output vafe_pkg::vafe_chan_t chan_ctrl [NUM_CHAN],
    output vafe_pkg::vafe_ctrl_t ctrl
);
    import vafe_pkg::*;

    // the decode below knows only red, green and blue
    if (NUM_CHAN != 3) begin : g_chan_check
        $error("vafe_regs supports exactly three channels");
    end

    // register storage
    logic [7:0] input_configuration;
    logic [7:0] gain [NUM_CHAN];
    logic [7:0] offset [NUM_CHAN];
    logic [7:0] offset_dac_config;

    // pin synchronisers: every pin is asynchronous to mclk
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic clamp_prev;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_meta <= {green_sync_input_pin, hsync_pin, enable_loop_pin,
                         coast_pin, clamp_pulse_pin};
            pin_sync <= pin_meta;
        end
    end

    // edge detector reads only the settled stage; its reset value matches
    // the idle low pin, so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            clamp_prev <= 1'b0;
        end else begin
            clamp_prev <= pin_sync[0];
        end
    end
    logic clamp_lvl;
    logic coast_lvl;
    logic loop_en;
    logic hsync_lvl;
    logic sog_lvl;
    logic clamp_edge;
    assign clamp_lvl = pin_sync[0];
    assign coast_lvl = pin_sync[1];
    assign loop_en = pin_sync[2];
    assign hsync_lvl = pin_sync[3];
    assign sog_lvl = pin_sync[4];
    assign clamp_edge = clamp_lvl & ~clamp_prev;

    // write channel: address and data accepted in either order
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // readies are offered for one cycle at a time, so a beat taken at
    // one edge can never be taken again at the next
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // both halves are released in the cycle the write commits
            if (aw_held & w_held) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held & w_held) begin
                w_held <= 1'b0;
            end
        end
    end

    logic do_write;
    logic [ADDR_W-1:0] wr_idx;
    logic wr_hit;
    // a write without the low lane enabled is answered but stores nothing
    assign do_write = aw_held & w_held & w_strb[0];
    assign wr_idx = aw_addr >> ADDR_SHIFT;
    assign wr_hit = (wr_idx >= IDX_INPUT_CFG) &&
                    (wr_idx <= IDX_OFFSET_DAC_CFG);

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (aw_held & w_held) begin
            s_axi_bvalid <= 1'b1;
            if (wr_hit) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only the low byte lane carries register data; reserved bits are
    // stored as zero so that reads never echo them back
    always_ff @(posedge mclk) begin
        if (reset) begin
            input_configuration <= RST_INPUT_CFG;
        end else if (do_write && wr_idx == IDX_INPUT_CFG) begin
            input_configuration <= w_data[7:0] & MASK_INPUT_CFG;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            offset_dac_config <= RST_OFFSET_DAC_CFG;
        end else if (do_write && wr_idx == IDX_OFFSET_DAC_CFG) begin
            offset_dac_config <= w_data[7:0] & MASK_OFFSET_DAC_CFG;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_store
            always_ff @(posedge mclk) begin
                if (reset) begin
                    gain[ch] <= RST_GAIN;
                    offset[ch] <= RST_OFFSET;
                end else if (do_write) begin
                    if (wr_idx == IDX_RED_GAIN + 8'(ch)) begin
                        gain[ch] <= w_data[7:0];
                    end
                    if (wr_idx == IDX_RED_OFFSET + 8'(ch)) begin
                        offset[ch] <= w_data[7:0];
                    end
                end
            end
        end
    endgenerate

    // read channel
    logic [ADDR_W-1:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;
    // unmapped indices answer an error with zero data
    assign rd_idx = s_axi_araddr >> ADDR_SHIFT;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_INPUT_CFG: rd_byte = input_configuration;
            IDX_RED_GAIN: rd_byte = gain[0];
            IDX_GREEN_GAIN: rd_byte = gain[1];
            IDX_BLUE_GAIN: rd_byte = gain[2];
            IDX_RED_OFFSET: rd_byte = offset[0];
            IDX_GREEN_OFFSET: rd_byte = offset[1];
            IDX_BLUE_OFFSET: rd_byte = offset[2];
            IDX_OFFSET_DAC_CFG: rd_byte = offset_dac_config;
            IDX_STATUS: rd_byte = {3'h0, ctrl.loop_run, ctrl.restore_run,
                                   ctrl.sync_out, coast_lvl, loop_en};
            default: rd_hit = 1'b0;
        endcase
    end

    // no new address is offered while read data waits for the host
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
        end
    end

    // read data is captured at the accept edge and held until rready
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // global control decode
    logic dc_mode;
    logic yuv_mode;
    logic composite;
    logic keep_on_coast;
    logic active_ok;
    assign dc_mode = input_configuration[BIT_COUPLING];
    assign yuv_mode = input_configuration[BIT_COLOUR];
    assign composite = input_configuration[BIT_SYNC_TYPE];
    assign keep_on_coast = input_configuration[BIT_COAST_CLAMP];
    // suspended while coasting unless coast clamp is set
    assign active_ok = ~coast_lvl | keep_on_coast;

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= '0;
        end else begin
            ctrl.input_select <= input_configuration[BIT_CHAN_SEL];
            ctrl.clamp_on <= ~dc_mode & clamp_lvl & active_ok;
            ctrl.restore_run <= ~dc_mode & clamp_lvl & active_ok;
            ctrl.loop_run <= loop_en & active_ok;
            ctrl.loop_start <= loop_en & active_ok & clamp_edge;
            ctrl.dac_range <= offset_dac_config[BIT_DAC_RANGE];
            ctrl.composite_mode <= composite;
            // separate mode always passes hsync
            if (composite & ~input_configuration[BIT_COMPOSITE_SYNC_SRC]) begin
                ctrl.sync_out <= sog_lvl;
            end else begin
                ctrl.sync_out <= hsync_lvl;
            end
        end
    end

    // per-channel analog controls; channel 1 is green
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            logic is_green;
            logic [1:0] lsb_field;
            assign is_green = (ch == GREEN_CH);
            assign lsb_field =
                offset_dac_config[LSB_FIELD_BASE + 2*ch +: 2];
            always_ff @(posedge mclk) begin
                if (reset) begin
                    chan_ctrl[ch] <= '0;
                    chan_ctrl[ch].clamp_level <= CLAMP_300MV;
                    chan_ctrl[ch].half_shift <= 1'b1;
                    chan_ctrl[ch].gain <= RST_GAIN;
                    chan_ctrl[ch].dac_code <= {RST_OFFSET, 2'b00};
                    chan_ctrl[ch].dig_offset <= RST_OFFSET;
                    chan_ctrl[ch].neg_to_clamp <= 1'b1;
                end else begin
                    if (yuv_mode & ~is_green) begin
                        chan_ctrl[ch].clamp_level <= CLAMP_600MV;
                        chan_ctrl[ch].half_shift <= 1'b0;
                        chan_ctrl[ch].black_target <= TARGET_MID;
                    end else begin
                        chan_ctrl[ch].clamp_level <= CLAMP_300MV;
                        chan_ctrl[ch].half_shift <= 1'b1;
                        chan_ctrl[ch].black_target <= TARGET_ZERO;
                    end
                    // gain has no transfer rule, so it follows at once
                    chan_ctrl[ch].gain <= gain[ch];
                    // staged values reach the dacs only on a clamp edge,
                    // so a half-written set of offsets never shows
                    if (clamp_edge) begin
                        if (loop_en) begin
                            chan_ctrl[ch].dig_offset <= offset[ch];
                        end else begin
                            chan_ctrl[ch].dac_code <=
                                {offset[ch], lsb_field};
                        end
                    end
                    chan_ctrl[ch].pos_to_clamp <=
                        ~dc_mode & clamp_lvl & active_ok;
                    chan_ctrl[ch].neg_to_clamp <= ~dc_mode;
                    chan_ctrl[ch].neg_to_pad <= dc_mode;
                end
            end
        end
    endgenerate
endmodule : vafe_regs

/* File: verif/vafe_host.sv */
// host model: register bus master for the video front end
`timescale 1ns/10ps
module vafe_host (
    // clock
    input wire logic mclk,
    // write side
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // reserved bits go out as given, so a caller can test that they are ignored
    task automatic wr(input logic [7:0] i, input logic [7:0] v,
                      output logic [1:0] r);
        logic ta = 1'b0;
        logic tw = 1'b0;
        @(posedge mclk);
        awaddr <= {i[5:0], 2'b00};
        wdata <= {24'h0, v};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge mclk);
            if (!ta && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] i, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        araddr <= {i[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : vafe_host

/* File: verif/vafe_monitor.sv */
// checker: bus handshake and analog control relations
`timescale 1ns/10ps
module vafe_monitor #(
    parameter int NUM_CHAN = 3
) (
    // clock, reset, bus
    input logic mclk,
    input logic reset,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    // pins and controls
    input logic hsync_pin,
    input logic clamp_pulse_pin,
    input vafe_pkg::vafe_chan_t chan_ctrl [NUM_CHAN],
    input vafe_pkg::vafe_ctrl_t ctrl
);
    import vafe_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    ac_tie_a: assert property (!chan_ctrl[1].neg_to_pad |->
        chan_ctrl[1].neg_to_clamp) else $error("negative input loose");
    dc_path_a: assert property (chan_ctrl[0].neg_to_pad |->
        !chan_ctrl[0].neg_to_clamp && !chan_ctrl[0].pos_to_clamp
        && !ctrl.clamp_on) else $error("dc input clamped");
    green_mode_a: assert property (chan_ctrl[1].half_shift &&
        chan_ctrl[1].clamp_level == CLAMP_300MV &&
        chan_ctrl[1].black_target == TARGET_ZERO) else $error("green mode");
    yuv_pair_a: assert property ((chan_ctrl[2].clamp_level ==
        CLAMP_600MV) == (chan_ctrl[2].black_target == TARGET_MID &&
        !chan_ctrl[2].half_shift)) else $error("yuv blue setup");
    sep_sync_a: assert property ((!ctrl.composite_mode &&
        $stable(hsync_pin))[*6] |-> ctrl.sync_out == hsync_pin)
        else $error("separate sync not hsync");
    gain_write_a: assert property ($changed(chan_ctrl[0].gain) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("gain moved without write");
    dac_clamp_a: assert property ($changed(chan_ctrl[2].dac_code) |->
        $past(clamp_pulse_pin, 2) || $past(clamp_pulse_pin, 3) ||
        $past(clamp_pulse_pin, 4)) else $error("dac moved off clamp");
    dig_clamp_a: assert property ($changed(chan_ctrl[1].dig_offset) |->
        $past(clamp_pulse_pin, 2) || $past(clamp_pulse_pin, 3) ||
        $past(clamp_pulse_pin, 4)) else $error("offset moved off clamp");
    start_pulse_a: assert property (ctrl.loop_start |->
        ($past(clamp_pulse_pin, 2) || $past(clamp_pulse_pin, 3) ||
        $past(clamp_pulse_pin, 4)) ##1 !ctrl.loop_start)
        else $error("bad loop start");

    cover property (ctrl.loop_start);
    cover property (chan_ctrl[0].neg_to_pad);
    cover property (ctrl.composite_mode && ctrl.sync_out);
endmodule : vafe_monitor

bind vafe_regs vafe_monitor #(.NUM_CHAN(NUM_CHAN)) vafe_monitor_inst (
    .mclk(mclk), .reset(reset), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .hsync_pin(hsync_pin), .clamp_pulse_pin(clamp_pulse_pin),
    .chan_ctrl(chan_ctrl), .ctrl(ctrl));

/* File: verif/vafe_regs_test.sv */
// testbench: register bank and control decode of the video front end
`timescale 1ns/10ps
module vafe_regs_test;
    import vafe_pkg::*;
    logic mclk, reset, clamp, coast, loop_en, hsync, gsync;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    vafe_chan_t chan_ctrl [3];
    vafe_ctrl_t ctrl;
    int err_count = 0;
    int n_compared = 0;
    int starts = 0;

    vafe_regs #(.NUM_CHAN(3)) vafe_regs_inst (.mclk(mclk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .clamp_pulse_pin(clamp), .coast_pin(coast),
        .enable_loop_pin(loop_en), .hsync_pin(hsync),
        .green_sync_input_pin(gsync), .chan_ctrl(chan_ctrl), .ctrl(ctrl));
    vafe_host vafe_host_inst (.mclk(mclk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (ctrl.loop_start === 1'b1) starts <= starts + 1;

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic settle;
        repeat (5) @(posedge mclk);
        #1;
    endtask : settle
    // the clamp pin is held three cycles so the two-stage sync cannot miss it
    task automatic pulse;
        @(posedge mclk);
        clamp <= 1'b1;
        repeat (3) @(posedge mclk);
        clamp <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
    endtask : pulse
    task automatic w(input logic [7:0] i, v, input logic [1:0] exp);
        logic [1:0] r;
        vafe_host_inst.wr(i, v, r);
        chk("bresp", r, exp);
    endtask : w
    task automatic rc(input logic [7:0] i, exp);
        logic [31:0] d;
        logic [1:0] r;
        vafe_host_inst.rd(i, d, r);
        chk("rdata", d, {24'h0, exp});
    endtask : rc

    task automatic t_reset;
        rc(IDX_INPUT_CFG, RST_INPUT_CFG);
        for (int i = 6; i < 9; i++) rc(8'(i), RST_GAIN);
        for (int i = 9; i < 12; i++) rc(8'(i), RST_OFFSET);
        rc(IDX_OFFSET_DAC_CFG, RST_OFFSET_DAC_CFG);
        chk("dac", chan_ctrl[2].dac_code, 10'h200);
    endtask : t_reset
    task automatic t_regs;
        w(IDX_INPUT_CFG, 8'hFF, RESP_OKAY);
        rc(IDX_INPUT_CFG, MASK_INPUT_CFG);
        w(IDX_OFFSET_DAC_CFG, 8'hFE, RESP_OKAY);
        rc(IDX_OFFSET_DAC_CFG, 8'hFC);
        w(IDX_OFFSET_DAC_CFG, 8'h00, RESP_OKAY);
        w(IDX_INPUT_CFG, 8'h00, RESP_OKAY);
        w(IDX_RED_GAIN, 8'hFF, RESP_OKAY);
        w(IDX_BLUE_GAIN, 8'h00, RESP_OKAY);
        w(8'h3F, 8'h12, RESP_SLVERR);
        settle;
        chk("gain_r", chan_ctrl[0].gain, 8'hFF);
        chk("gain_g", chan_ctrl[1].gain, RST_GAIN);
        chk("gain_b", chan_ctrl[2].gain, 8'h00);
        rc(IDX_BLUE_GAIN, 8'h00);
    endtask : t_regs
    task automatic t_couple;
        for (int m = 0; m < 4; m++) begin
            w(IDX_INPUT_CFG, 8'(m << 1), RESP_OKAY);
            @(posedge mclk);
            clamp <= 1'b1;
            settle;
            chk("pclamp", chan_ctrl[1].pos_to_clamp, !m[0]);
            chk("clamp_on", ctrl.clamp_on, !m[0]);
            chk("restore", ctrl.restore_run, !m[0]);
            @(posedge mclk);
            clamp <= 1'b0;
            pulse;
            chk("npad", chan_ctrl[0].neg_to_pad, m[0]);
            chk("ntie", chan_ctrl[2].neg_to_clamp, !m[0]);
            chk("lvl_r", chan_ctrl[0].clamp_level,
                m[1] ? CLAMP_600MV : CLAMP_300MV);
            chk("lvl_g", chan_ctrl[1].clamp_level, CLAMP_300MV);
            chk("shift_b", chan_ctrl[2].half_shift, !m[1]);
            chk("tgt_b", chan_ctrl[2].black_target,
                m[1] ? TARGET_MID : TARGET_ZERO);
        end
    endtask : t_couple
    task automatic t_sync;
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk);
            hsync <= p[0];
            gsync <= !p[0];
            for (int s = 0; s < 4; s++) begin
                w(IDX_INPUT_CFG, 8'((s << 3) | 1), RESP_OKAY);
                settle;
                chk("sel", ctrl.input_select, 1'b1);
                chk("mode", ctrl.composite_mode, s[0]);
                chk("sync", ctrl.sync_out, (s == 1) ? !p[0] : p[0]);
            end
        end
    endtask : t_sync
    task automatic t_offset;
        int s0;
        w(IDX_INPUT_CFG, 8'h00, RESP_OKAY);
        w(IDX_RED_OFFSET, 8'h3C, RESP_OKAY);
        w(IDX_BLUE_OFFSET, 8'hC3, RESP_OKAY);
        w(IDX_OFFSET_DAC_CFG, 8'hE5, RESP_OKAY);
        settle;
        chk("hold_r", chan_ctrl[0].dac_code, 10'h200);
        chk("range", ctrl.dac_range, 1'b1);
        pulse;
        chk("dac_r", chan_ctrl[0].dac_code, {8'h3C, 2'b01});
        chk("dac_g", chan_ctrl[1].dac_code, {8'h80, 2'b10});
        chk("dac_b", chan_ctrl[2].dac_code, {8'hC3, 2'b11});
        @(posedge mclk);
        loop_en <= 1'b1;
        w(IDX_GREEN_OFFSET, 8'h00, RESP_OKAY);
        settle;
        s0 = starts;
        pulse;
        chk("dig_g", chan_ctrl[1].dig_offset, 8'h00);
        chk("start", starts - s0, 1);
        for (int c = 0; c < 2; c++) begin
            w(IDX_INPUT_CFG, 8'(c << 5), RESP_OKAY);
            @(posedge mclk);
            coast <= 1'b1;
            settle;
            s0 = starts;
            pulse;
            chk("coast", starts - s0, c);
            chk("loop_run", ctrl.loop_run, c);
        end
        rc(IDX_STATUS, 8'h17);
    endtask : t_offset

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    initial begin
        {reset, clamp, coast, loop_en, hsync, gsync} = 6'h20;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_regs;
        t_couple;
        t_sync;
        t_offset;
        test_done;
    end
    initial begin
        #200000;
        err_count++;
        test_done;
    end
endmodule : vafe_regs_test
